// *** logic/ssp_port.sv ***
// Eight-pin port shared by general I/O, the serial interfaces and bus direction control,
// with an SPI shift engine and an APB register file.
// Assumes an APB master on pclk; pins and external SCK are asynchronous and are synchronised here.
// Function
// - Eight two-way pins, each general I/O or handed to serial or bus control.
// - Reading pin data returns the sensed pin level for input bits.
// - Reading pin data returns the driven level for output bits.
// - Pin data writes always update the latch; it drives only general outputs.
// - Direction bit 0 makes the pin input, 1 makes it output.
// - Expanded mode hands pins 6 and 7 to strobe and read/write outputs.
// - With SPI on, pin 5 is slave select; slave mode ignores its direction bit.
// - Master mode: pin 5 direction 0 is fault input, 1 is general output.
// - SPI input roles on pins 2 to 4 force input regardless of direction.
// - SPI output roles on pins 2 to 4 drive only when direction bit set.
// - Phase 0 slave data write while selected raises write collision.
// - Phase 1 accepts back-to-back bytes while select stays low.
// - Polarity picks clock idle level; phase picks transfer format.
// - Unselected slave floats its MISO output.
`timescale 1ns/1ps
module ssp_port #(
    parameter int SCK_HALF = ssp_pkg::SCK_HALF_DEF
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ssp_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [ssp_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [ssp_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [ssp_pkg::PORT_W-1:0]  pin_i,
    output logic      [ssp_pkg::PORT_W-1:0]  pin_o,
    output logic      [ssp_pkg::PORT_W-1:0]  pin_oe,
    input  wire logic                        sci_txd,
    input  wire logic                        bus_addr_strobe,
    input  wire logic                        bus_read_write,
    output logic                             irq
);
    // ------------------------------------
    // Declarations
    // ------------------------------------
    localparam int DIV_W = $clog2(SCK_HALF + 1);

    logic [ssp_pkg::PORT_W-1:0] pin_lvl;
    logic [7:0]                 latch_q;
    logic [7:0]                 dir_q;
    logic [2:0]                 cfg_q;
    logic [7:0]                 ctrl_q;
    logic [7:0]                 rx_q;
    logic [7:0]                 sh_q;
    logic [7:0]                 rxbit_q;
    logic [2:0]                 cnt_q;
    logic [ssp_pkg::STS_W-1:0]  sts_q;
    logic [ssp_pkg::STS_W-1:0]  sts_d;
    logic [ssp_pkg::STS_W-1:0]  mask_q;
    logic [DIV_W-1:0]           div_q;
    logic [3:0]                 half_q;
    logic                       sck_q;
    logic                       sck_prev_q;
    ssp_pkg::ssp_mst_state_t    mst_q;
    logic [7:0]                 oe_d;
    logic [7:0]                 out_d;
    logic [31:0]                rdata_d;
    logic                       addr_ok;

    wire logic acc      = psel & penable & pready;
    wire logic wr_en    = acc & pwrite & pstrb[0];
    wire logic rd_en    = acc & ~pwrite;
    wire logic spi_on   = ctrl_q[ssp_pkg::CTRL_SPI_EN];
    wire logic master   = ctrl_q[ssp_pkg::CTRL_MASTER];
    wire logic cpol     = ctrl_q[ssp_pkg::CTRL_CPOL];
    wire logic cpha     = ctrl_q[ssp_pkg::CTRL_CPHA];
    wire logic sel_low  = ~pin_lvl[ssp_pkg::PIN_SEL];
    wire logic slave_on = spi_on & ~master;
    wire logic fault_in = spi_on & master & ~dir_q[ssp_pkg::PIN_SEL];

    // ------------------------------------
    // Pin synchroniser
    // ------------------------------------
    ssp_pin_sync #(
        .W       (ssp_pkg::PORT_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   (pin_i),
        .level_o (pin_lvl)
    );

    // ------------------------------------
    // Edge sources for the shift engine
    // ------------------------------------
    // Master edges come from the internal divider, slave edges from the filtered pin
    logic mst_tick;
    logic lead_e;
    logic trail_e;
    logic din;
    logic slv_edge;

    assign mst_tick = (mst_q == ssp_pkg::SSP_RUN) && (div_q == DIV_W'(SCK_HALF - 1));
    assign slv_edge = slave_on & sel_low & (pin_lvl[ssp_pkg::PIN_SCK] != sck_prev_q);

    always_comb begin
        lead_e  = 1'b0;
        trail_e = 1'b0;
        din     = 1'b0;
        if (spi_on && master) begin
            lead_e  = mst_tick & ~half_q[0];
            trail_e = mst_tick & half_q[0];
            din     = pin_lvl[ssp_pkg::PIN_MISO];
        end else if (slave_on) begin
            lead_e  = slv_edge & (pin_lvl[ssp_pkg::PIN_SCK] != cpol);
            trail_e = slv_edge & (pin_lvl[ssp_pkg::PIN_SCK] == cpol);
            din     = pin_lvl[ssp_pkg::PIN_MOSI];
        end
    end

    wire logic samp_e  = cpha ? trail_e : lead_e;
    wire logic shift_e = cpha ? lead_e : trail_e;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pin_lvl[ssp_pkg::PIN_SCK];
        end
    end

    // ------------------------------------
    // Data write acceptance and collision
    // ------------------------------------
    logic data_wr;
    logic wcol;
    logic load;
    logic byte_done;
    logic modf;

    assign data_wr = wr_en && (paddr == ssp_pkg::OFS_SER_DATA);
    // Phase 0 slave: a write while selected collides with the byte in flight
    assign wcol = data_wr && spi_on &&
                  ((slave_on && !cpha && sel_low) ||
                   (cnt_q != 3'h0) || (mst_q == ssp_pkg::SSP_RUN));
    assign load = data_wr && !wcol;
    assign modf = fault_in && sel_low;
    assign byte_done = (samp_e && cpha && cnt_q == ssp_pkg::BIT_LAST) ||
                       (shift_e && !cpha && cnt_q == ssp_pkg::BIT_LAST);

    // ------------------------------------
    // Shift engine
    // ------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q    <= ssp_pkg::RST_BYTE;
            rxbit_q <= ssp_pkg::RST_BYTE;
            cnt_q   <= 3'h0;
            rx_q    <= ssp_pkg::RST_BYTE;
        end else if (load) begin
            sh_q  <= pwdata[7:0];
            cnt_q <= 3'h0;
        end else if (!spi_on || modf || (slave_on && !sel_low)) begin
            // Deselect restarts the byte count, so phase 0 needs a reselect per byte
            cnt_q <= 3'h0;
        end else begin
            if (samp_e) begin
                rxbit_q[0] <= din;
                if (cpha) begin
                    // Phase 1 wraps the count and keeps going while select stays low
                    if (cnt_q == ssp_pkg::BIT_LAST) begin
                        sh_q  <= {sh_q[6:0], din};
                        rx_q  <= {sh_q[6:0], din};
                        cnt_q <= 3'h0;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
            end
            if (shift_e) begin
                if (!cpha) begin
                    sh_q <= {sh_q[6:0], rxbit_q[0]};
                    if (cnt_q == ssp_pkg::BIT_LAST) begin
                        rx_q  <= {sh_q[6:0], rxbit_q[0]};
                        cnt_q <= 3'h0;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end else if (cnt_q != 3'h0) begin
                    sh_q <= {sh_q[6:0], rxbit_q[0]};
                end
            end
        end
    end

    // ------------------------------------
    // Master clock generator
    // ------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_q  <= ssp_pkg::SSP_IDLE;
            div_q  <= '0;
            half_q <= 4'h0;
            sck_q  <= 1'b0;
        end else begin
            case (mst_q)
                ssp_pkg::SSP_IDLE: begin
                    sck_q  <= cpol;
                    div_q  <= '0;
                    half_q <= 4'h0;
                    if (load && spi_on && master) begin
                        mst_q <= ssp_pkg::SSP_RUN;
                    end
                end
                ssp_pkg::SSP_RUN: begin
                    if (modf || !spi_on || !master) begin
                        mst_q <= ssp_pkg::SSP_IDLE;
                    end else if (mst_tick) begin
                        div_q  <= '0;
                        sck_q  <= ~sck_q;
                        half_q <= half_q + 4'h1;
                        if (half_q == ssp_pkg::HALF_LAST) begin
                            mst_q <= ssp_pkg::SSP_IDLE;
                        end
                    end else begin
                        div_q <= div_q + DIV_W'(1);
                    end
                end
                default: mst_q <= ssp_pkg::SSP_IDLE;
            endcase
        end
    end

    // ------------------------------------
    // Pin ownership
    // ------------------------------------
    always_comb begin
        oe_d  = dir_q;
        out_d = latch_q;
        if (cfg_q[ssp_pkg::CFG_SCI_RX]) begin
            oe_d[ssp_pkg::PIN_SCI_RX] = 1'b0;
        end
        if (cfg_q[ssp_pkg::CFG_SCI_TX]) begin
            oe_d[ssp_pkg::PIN_SCI_TX]  = 1'b1;
            out_d[ssp_pkg::PIN_SCI_TX] = sci_txd;
        end
        if (spi_on && master) begin
            oe_d[ssp_pkg::PIN_MISO]  = 1'b0;
            out_d[ssp_pkg::PIN_MOSI] = sh_q[7];
            out_d[ssp_pkg::PIN_SCK]  = sck_q;
        end else if (slave_on) begin
            oe_d[ssp_pkg::PIN_MOSI]  = 1'b0;
            oe_d[ssp_pkg::PIN_SCK]   = 1'b0;
            oe_d[ssp_pkg::PIN_SEL]   = 1'b0;
            // Driver only while selected; the direction bit still gates it
            oe_d[ssp_pkg::PIN_MISO]  = dir_q[ssp_pkg::PIN_MISO] & sel_low;
            out_d[ssp_pkg::PIN_MISO] = sh_q[7];
        end
        if (fault_in) begin
            oe_d[ssp_pkg::PIN_SEL] = 1'b0;
        end
        if (cfg_q[ssp_pkg::CFG_EXPANDED]) begin
            oe_d[ssp_pkg::PIN_STROBE]  = 1'b1;
            oe_d[ssp_pkg::PIN_RW]      = 1'b1;
            out_d[ssp_pkg::PIN_STROBE] = bus_addr_strobe;
            out_d[ssp_pkg::PIN_RW]     = bus_read_write;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= ssp_pkg::RST_BYTE;
            pin_o  <= ssp_pkg::RST_BYTE;
        end else begin
            pin_oe <= oe_d;
            pin_o  <= out_d;
        end
    end

    // ------------------------------------
    // Software registers
    // ------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= ssp_pkg::RST_BYTE;
            dir_q   <= ssp_pkg::RST_BYTE;
            cfg_q   <= 3'h0;
            mask_q  <= ssp_pkg::RST_STS;
        end else if (wr_en) begin
            case (paddr)
                ssp_pkg::OFS_PIN_DATA: latch_q <= pwdata[7:0];
                ssp_pkg::OFS_PIN_DIR:  dir_q   <= pwdata[7:0];
                ssp_pkg::OFS_PIN_CFG:  cfg_q   <= pwdata[2:0];
                ssp_pkg::OFS_MASK:     mask_q  <= pwdata[ssp_pkg::STS_W-1:0];
                default: ;
            endcase
        end
    end

    // A mode fault drops the SPI enable and master bits; pins whose direction bit is set go on driving the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ssp_pkg::RST_BYTE;
        end else if (modf) begin
            ctrl_q[ssp_pkg::CTRL_SPI_EN] <= 1'b0;
            ctrl_q[ssp_pkg::CTRL_MASTER] <= 1'b0;
        end else if (wr_en && paddr == ssp_pkg::OFS_SER_CTRL) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // ------------------------------------
    // Status and interrupt
    // ------------------------------------
    // Read clears, but an event in the same cycle survives the clear
    always_comb begin
        sts_d = sts_q;
        if (rd_en && paddr == ssp_pkg::OFS_STATUS) begin
            sts_d = ssp_pkg::RST_STS;
        end
        if (byte_done) begin
            sts_d[ssp_pkg::STS_DONE] = 1'b1;
        end
        if (wcol) begin
            sts_d[ssp_pkg::STS_WCOL] = 1'b1;
        end
        if (modf) begin
            sts_d[ssp_pkg::STS_MODF] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= ssp_pkg::RST_STS;
            irq   <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq   <= |(sts_d & mask_q);
        end
    end

    // ------------------------------------
    // APB read path
    // ------------------------------------
    logic [7:0] pin_rd;
    genvar b;
    generate
        for (b = 0; b < ssp_pkg::PORT_W; b++) begin : g_rd
            // Output bits read back what the driver is fed, inputs the sensed level
            assign pin_rd[b] = pin_oe[b] ? pin_o[b] : pin_lvl[b];
        end
    endgenerate

    always_comb begin
        rdata_d = 32'h0;
        addr_ok = 1'b1;
        case (paddr)
            ssp_pkg::OFS_PIN_DATA: rdata_d[7:0] = pin_rd;
            ssp_pkg::OFS_PIN_DIR:  rdata_d[7:0] = dir_q;
            ssp_pkg::OFS_PIN_CFG:  rdata_d[2:0] = cfg_q;
            ssp_pkg::OFS_SER_CTRL: rdata_d[7:0] = ctrl_q;
            ssp_pkg::OFS_SER_DATA: rdata_d[7:0] = rx_q;
            ssp_pkg::OFS_STATUS:   rdata_d[ssp_pkg::STS_W-1:0] = sts_q;
            ssp_pkg::OFS_MASK:     rdata_d[ssp_pkg::STS_W-1:0] = mask_q;
            default:               addr_ok = 1'b0;
        endcase
    end

    // One wait state: ready rises at the end of the first access cycle and falls after the handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? 32'h0 : rdata_d;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
    end
endmodule : ssp_port

// *** logic/ssp_pkg.sv ***
// Shared constants for the shared serial pin port: register map, field positions, pin roles.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package ssp_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          PORT_W         = 8;
    localparam logic [7:0]  OFS_PIN_DATA   = 8'h00;
    localparam logic [7:0]  OFS_PIN_DIR    = 8'h04;
    localparam logic [7:0]  OFS_PIN_CFG    = 8'h08;
    localparam logic [7:0]  OFS_SER_CTRL   = 8'h0c;
    localparam logic [7:0]  OFS_SER_DATA   = 8'h10;
    localparam logic [7:0]  OFS_STATUS     = 8'h14;
    localparam logic [7:0]  OFS_MASK       = 8'h18;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int          CFG_EXPANDED   = 0;
    localparam int          CFG_SCI_RX     = 1;
    localparam int          CFG_SCI_TX     = 2;
    localparam int          CTRL_SPI_EN    = 6;
    localparam int          CTRL_MASTER    = 4;
    localparam int          CTRL_CPOL      = 3;
    localparam int          CTRL_CPHA      = 2;
    localparam int          STS_DONE       = 0;
    localparam int          STS_WCOL       = 1;
    localparam int          STS_MODF       = 2;
    localparam int          STS_W          = 3;
    // ------------------------------------------------------------
    // Pin roles
    // ------------------------------------------------------------
    localparam int          PIN_SCI_RX     = 0;
    localparam int          PIN_SCI_TX     = 1;
    localparam int          PIN_MISO       = 2;
    localparam int          PIN_MOSI       = 3;
    localparam int          PIN_SCK        = 4;
    localparam int          PIN_SEL        = 5;
    localparam int          PIN_STROBE     = 6;
    localparam int          PIN_RW         = 7;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [2:0]  RST_STS        = 3'h0;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [3:0]  HALF_LAST      = 4'hf;
    localparam int          SCK_HALF_DEF   = 4;

    typedef enum logic {
        SSP_IDLE,
        SSP_RUN
    } ssp_mst_state_t;
endpackage : ssp_pkg

// *** logic/ssp_pin_sync.sv ***
// Per-pin input synchroniser with three flops and an agreement filter.
// Assumes pins are asynchronous to pclk; level changes once stages two and three agree.
`timescale 1ns/1ps
module ssp_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q       <= 1'b0;
                    s2_q       <= 1'b0;
                    s3_q       <= 1'b0;
                    level_o[g] <= 1'b0;
                end else begin
                    s1_q <= pin_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        level_o[g] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule : ssp_pin_sync

// *** dv/ssp_port_monitor.sv ***
// Checker for pin ownership and collision interrupt of ssp_port.
// Assumes a bench that never provokes a mode fault.
`timescale 1ns/1ps
module ssp_port_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pin_i,
    input wire logic [7:0]  pin_o,
    input wire logic [7:0]  pin_oe,
    input wire logic        bus_addr_strobe,
    input wire logic        irq
);
    logic [7:0] dir_q, dat_q, cfg_q, ctl_q, msk_q;
    logic [3:0] low_q;
    logic       wr, en, slv;
    assign wr  = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign en  = ctl_q[ssp_pkg::CTRL_SPI_EN];
    assign slv = en && !ctl_q[ssp_pkg::CTRL_MASTER];
    // Shadow copies let pin ownership be judged without the register bodies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dir_q, dat_q, cfg_q, ctl_q, msk_q} <= '0;
        end else if (wr) begin
            if (paddr == ssp_pkg::OFS_PIN_DIR) dir_q <= pwdata[7:0];
            if (paddr == ssp_pkg::OFS_PIN_DATA) dat_q <= pwdata[7:0];
            if (paddr == ssp_pkg::OFS_PIN_CFG) cfg_q <= pwdata[7:0];
            if (paddr == ssp_pkg::OFS_SER_CTRL) ctl_q <= pwdata[7:0];
            if (paddr == ssp_pkg::OFS_MASK) msk_q <= pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 4'h0;
        else if (pin_i[5]) low_q <= 4'h0;
        else if (low_q != 4'hf) low_q <= low_q + 4'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_held;
        $stable({dir_q, dat_q, cfg_q, ctl_q}) [*2];
    endsequence
    sequence s_sel_write;
        slv && !ctl_q[ssp_pkg::CTRL_CPHA] && low_q == 4'hf && msk_q[1] && wr && paddr == ssp_pkg::OFS_SER_DATA;
    endsequence
    AST_RST_INPUTS: assert property ($rose(presetn) |-> pin_oe == 8'h00 ##1 pin_oe == 8'h00)
        else $error("pins driven after reset");
    AST_GPIO_DIR: assert property (s_held ##0 (!en && cfg_q[2:0] == 3'h0) |-> pin_oe == dir_q)
        else $error("direction not followed");
    AST_GPIO_LATCH: assert property (s_held ##0 (!en && cfg_q[2:0] == 3'h0) |-> ((pin_o ^ dat_q) & dir_q) == 8'h00)
        else $error("latch not driven");
    AST_EXP_PINS: assert property (s_held ##0 cfg_q[0] |-> pin_oe[7:6] == 2'b11 && pin_o[6] == $past(bus_addr_strobe))
        else $error("bus pins not taken");
    AST_SLV_SEL: assert property (s_held ##0 slv |-> !pin_oe[5] && pin_oe[4:3] == 2'b00)
        else $error("slave pins driven");
    AST_MST_SEL: assert property (s_held ##0 (en && !slv) |-> pin_oe[5] == dir_q[5] && !pin_oe[2])
        else $error("master pin roles wrong");
    AST_SPI_OUT: assert property (s_held ##0 en |-> (pin_oe[4:2] & ~dir_q[4:2]) == 3'h0)
        else $error("serial pin driven without direction");
    AST_MISO_FLOAT: assert property ((slv && pin_i[5]) [*8] |-> !pin_oe[2])
        else $error("unselected slave drives data");
    AST_WCOL_IRQ: assert property (s_sel_write |-> ##[1:4] irq)
        else $error("no collision interrupt");
endmodule : ssp_port_monitor
bind ssp_port ssp_port_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .bus_addr_strobe(bus_addr_strobe), .irq(irq));

// *** dv/ssp_board.sv ***
// Board model: drives every released pin and plays the far serial party.
// Assumes the bench calls load before a master transfer and send for slave ones.
`timescale 1ns/1ps
module ssp_board (
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    output logic      [7:0] pin_i
);
    logic [7:0] ext = 8'h20;
    logic [7:0] tx  = 8'h00;
    logic [7:0] rx  = 8'h00;
    logic       mst = 1'b0;
    assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
    // Slave role: sample on the rising clock, next bit on the falling one
    always @(posedge pin_o[4]) begin
        if (mst) rx = {rx[6:0], pin_o[3]};
    end
    always @(negedge pin_o[4]) begin
        if (mst) tx = {tx[6:0], 1'b0};
        if (mst) ext[2] = tx[7];
    end
    task automatic load(input logic [7:0] b);
        tx = b;
        ext[2] = b[7];
        mst = 1'b1;
    endtask : load
    // Master role, phase 1 and polarity 0, clock stands still outside frames
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ext[4] = 1'b1;
            ext[3] = b[i];
            #32;
            ext[4] = 1'b0;
            #32;
        end
    endtask : send
endmodule : ssp_board

// *** dv/ssp_port_tb.sv ***
// Self-checking bench for ssp_port over APB against a register model.
// Assumes the board drives released pins; SCK_HALF is 8 to outlast pin sync.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module ssp_port_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr, pin_i, pin_o, pin_oe;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rnd;
    int          fail_count, check_count, m_dir, m_dat;
    int          rxq[$];
    ssp_port #(.SCK_HALF(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .sci_txd(rnd[0]),
        .bus_addr_strobe(rnd[2]), .bus_read_write(rnd[1]), .irq(irq));
    ssp_board i_brd (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        rnd <= lfsr(rnd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) fail_count++;
        if (n == 50) results();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rnd = 16'h9be3;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(pin_oe, 8'h00)
        apb(1'b0, ssp_pkg::OFS_PIN_DIR, 8'h00);
        `CHK(rd, 32'h00000000)
        for (int k = 0; k < 6; k++) begin
            m_dat = rnd[7:0];
            m_dir = rnd[15:8];
            i_brd.ext <= rnd[11:4];
            apb(1'b1, ssp_pkg::OFS_PIN_DATA, m_dat[7:0]);
            apb(1'b1, ssp_pkg::OFS_PIN_DIR, m_dir[7:0]);
            idle(8);
            `CHK(pin_oe, m_dir[7:0])
            `CHK(pin_o & pin_oe, m_dat[7:0] & m_dir[7:0])
            apb(1'b0, ssp_pkg::OFS_PIN_DATA, 8'h00);
            `CHK(rd[7:0], (m_dat[7:0] & m_dir[7:0]) | (i_brd.ext & ~m_dir[7:0]))
        end
        apb(1'b0, 8'h1c, 8'h00);
        `CHK({err, rd}, {1'b1, 32'h00000000})
        apb(1'b1, ssp_pkg::OFS_PIN_CFG, 8'h07);
        idle(4);
        `CHK({pin_oe[7:6], pin_oe[1:0]}, 4'he)
        `CHK({pin_o[7:6], pin_o[1]}, {rnd[1], rnd[2], rnd[0]})
        apb(1'b1, ssp_pkg::OFS_PIN_CFG, 8'h00);
        i_brd.ext <= 8'h20;
        apb(1'b1, ssp_pkg::OFS_PIN_DIR, 8'hff);
        apb(1'b1, ssp_pkg::OFS_SER_CTRL, 8'h40);
        idle(8);
        `CHK(pin_oe[5:2], 4'h0)
        i_brd.ext <= 8'h00;
        idle(8);
        `CHK(pin_oe[5:2], 4'h1)
        // Masked collision first, then unmasking must raise the stored event
        apb(1'b1, ssp_pkg::OFS_SER_DATA, 8'h5a);
        idle(3);
        `CHK(irq, 1'b0)
        apb(1'b1, ssp_pkg::OFS_MASK, 8'h02);
        idle(3);
        `CHK(irq, 1'b1)
        apb(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        `CHK(rd[2:0], 3'h2)
        idle(3);
        `CHK(irq, 1'b0)
        apb(1'b1, ssp_pkg::OFS_SER_DATA, 8'h5a);
        idle(3);
        `CHK(irq, 1'b1)
        apb(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        apb(1'b1, ssp_pkg::OFS_SER_CTRL, 8'h44);
        apb(1'b1, ssp_pkg::OFS_SER_DATA, 8'h81);
        apb(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        `CHK(rd[1], 1'b0)
        for (int k = 0; k < 2; k++) begin
            rxq.push_back(rnd[7:0]);
            i_brd.send(rnd[7:0]);
            idle(10);
            apb(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
            `CHK(rd[0], 1'b1)
            apb(1'b0, ssp_pkg::OFS_SER_DATA, 8'h00);
            `CHK(rd[7:0], 8'(rxq.pop_front()))
        end
        i_brd.ext <= 8'h20;
        idle(8);
        `CHK(pin_oe[2], 1'b0)
        apb(1'b1, ssp_pkg::OFS_PIN_DIR, 8'h38);
        apb(1'b1, ssp_pkg::OFS_SER_CTRL, 8'h58);
        idle(4);
        `CHK(pin_o[4], 1'b1)
        apb(1'b1, ssp_pkg::OFS_SER_CTRL, 8'h50);
        // SCK must settle low first
        idle(2);
        i_brd.load(8'h3c);
        apb(1'b1, ssp_pkg::OFS_SER_DATA, 8'ha5);
        idle(160);
        `CHK(i_brd.rx, 8'ha5)
        apb(1'b0, ssp_pkg::OFS_SER_DATA, 8'h00);
        `CHK(rd[7:0], 8'h3c)
        results();
    end
endmodule : ssp_port_tb
